// ---- core/rciv_defs.vh ----
// Purpose: constants for the reset cause and interrupt vector unit
// Assumes: 32-bit classic wishbone slave, word aligned registers
// Notes:   offsets are byte addresses
`ifndef RCIV_DEFS_VH
`define RCIV_DEFS_VH
`define RCIV_OFF_IRQ_CTRL   6'h00
`define RCIV_OFF_PFLAG_A    6'h04
`define RCIV_OFF_PFLAG_B    6'h08
`define RCIV_OFF_PMASK_A    6'h0C
`define RCIV_OFF_PMASK_B    6'h10
`define RCIV_OFF_CAUSE      6'h14
`define RCIV_OFF_PRESCALE   6'h18
`define RCIV_OFF_DIR        6'h1C
`define RCIV_OFF_PC         6'h20
`define RCIV_BIT_GIE        7
`define RCIV_BIT_PERIPHERAL_IRQ_GATE       6
`define RCIV_BIT_EDGE_EN    4
`define RCIV_BIT_CHG_EN     3
`define RCIV_BIT_TMR_EN     5
`define RCIV_BIT_TMR_FLAG   2
`define RCIV_BIT_EDGE_FLAG  1
`define RCIV_BIT_CHG_FLAG   0
`define RCIV_BIT_RSVD_A     7
`define RCIV_BIT_WDX        4
`define RCIV_BIT_PDN        3
`define RCIV_BIT_POR        1
`define RCIV_BIT_BOR        0
`define RCIV_RESET_VEC      13'h0000
`define RCIV_IRQ_VEC        13'h0004
`define RCIV_ONES           8'hFF
`define RCIV_EXT_LAT_MIN    3
`define RCIV_IRQ_TICKS      2'h2
`endif

// ---- core/rciv_unit.v ----
// Purpose: reset cause flags, initial pc selection and interrupt vectoring
// Assumes: one clock, core advances one instruction per instr_tick_i pulse
// Notes:   reset and wake events are one-cycle pulses from the core sequencer
`timescale 1ns/10ps
`include "rciv_defs.vh"
// Operation
// - power-on: watchdog and power-down flags set, power-on flag cleared, pc zero
// - master clear while running: pc zero, cause flags unchanged
// - master clear in sleep: watchdog flag set, power-down cleared, pc zero
// - watchdog awake resets pc zero; in sleep wakes to pc+1, both cleared
// - brown-out: brownout cleared, watchdog and power-down set, pc zero
// - irq wake: watchdog set, power-down cleared; vector if global enable else pc+1
// - any reset forces prescaler and direction registers to all ones
// - fourteen sources with own flags, masks and a global enable
// - flags set on event regardless of mask, gate or global enable
// - global enable bit 7 gates all; taken when enable, flag, mask set, peripherals also needing gate bit 6
// - every reset clears the global enable
// - taking irq clears global enable, pushes return, loads vector
// - return-from-irq sets global enable again
// - core flags in control register; peripheral ones in two flag/mask pairs
// - external events vector three or four instruction cycles later
// - latency independent of one or two cycle instructions
// - irq wake leaves at least one flag set showing the cause
module rciv_unit #(
  parameter PC_W = 13
) (
  input  wire            clk_i,
  input  wire            rst_i,
  input  wire [5:0]      adr_i,
  input  wire [31:0]     dat_i,
  output reg  [31:0]     dat_o,
  input  wire            we_i,
  input  wire [3:0]      sel_i,
  input  wire            cyc_i,
  input  wire            stb_i,
  output reg             ack_o,
  input  wire            por_evt_i,
  input  wire            bor_evt_i,
  input  wire            master_clear_pin_i,
  input  wire            watchdog_evt_i,
  input  wire            sleeping_i,
  input  wire            instr_tick_i,
  input  wire [PC_W-1:0] pc_i,
  input  wire            return_from_irq_op_i,
  input  wire            edge_irq_pin_i,
  input  wire            port_change_i,
  input  wire            timer_zero_ovf_i,
  input  wire [6:0]      periph_evt_a_i,
  input  wire [3:0]      periph_evt_b_i,
  output reg             pc_load_o,
  output reg  [PC_W-1:0] pc_value_o,
  output reg             stack_push_o,
  output reg  [PC_W-1:0] stack_data_o,
  output reg             wake_o,
  output wire            irq_pending_o,
  output wire [7:0]      prescale_cfg_o,
  output wire [7:0]      port_dir_o
);

  reg  [7:0] ctrl_q;
  reg  [7:0] pfa_q;
  reg  [3:0] pfb_q;
  reg  [7:0] pma_q;
  reg  [3:0] pmb_q;
  reg        wdx_q;
  reg        pdn_q;
  reg        por_q;
  reg        bor_q;
  reg  [7:0] pre_q;
  reg  [7:0] dir_q;
  reg  [1:0] master_clear_pin_s_q;
  reg  [1:0] edge_s_q;
  reg  [1:0] chg_s_q;
  reg        master_clear_pin_old_q;
  reg        edge_old_q;
  reg        chg_old_q;
  reg        pend_q;
  reg        woke_q;
  reg  [1:0] lat_q;

  wire       bus_req = cyc_i & stb_i & ~ack_o;
  wire       wr      = bus_req & we_i & sel_i[0];
  wire       master_clear_pin_evt = master_clear_pin_s_q[1] & ~master_clear_pin_old_q;
  wire       edge_evt = edge_s_q[1] & ~edge_old_q;
  wire       chg_evt  = chg_s_q[1] ^ chg_old_q;
  wire       any_reset = por_evt_i | bor_evt_i | master_clear_pin_evt |
                         (watchdog_evt_i & ~sleeping_i);
  // flags and masks, control register core sources plus peripherals
  wire       core_hit = (ctrl_q[`RCIV_BIT_TMR_FLAG] & ctrl_q[`RCIV_BIT_TMR_EN]) |
                        (ctrl_q[`RCIV_BIT_EDGE_FLAG] & ctrl_q[`RCIV_BIT_EDGE_EN]) |
                        (ctrl_q[`RCIV_BIT_CHG_FLAG] & ctrl_q[`RCIV_BIT_CHG_EN]);
  wire       per_hit  = ctrl_q[`RCIV_BIT_PERIPHERAL_IRQ_GATE] &
                        ((|(pfa_q & pma_q)) | (|(pfb_q & pmb_q)));
  wire       req_any  = core_hit | per_hit;
  wire       take     = req_any & ctrl_q[`RCIV_BIT_GIE] & ~sleeping_i;
  wire [7:0] cause    = {3'h0, wdx_q, pdn_q, 1'b0, por_q, bor_q};
  // return address and wake target are the instruction after the current one
  wire [PC_W-1:0] ret_pc = pc_i + {{(PC_W-1){1'b0}}, 1'b1};
  // a sleeping core wakes on any enabled flag, global enable or not
  wire       irq_wake = sleeping_i & req_any & ~woke_q & ~any_reset & ~watchdog_evt_i;
  // write strobes for the two peripheral flag registers
  wire       wr_pfa   = wr & (adr_i == `RCIV_OFF_PFLAG_A);
  wire       wr_pfb   = wr & (adr_i == `RCIV_OFF_PFLAG_B);
  wire [7:0] evt_a    = {1'b0, periph_evt_a_i};
  wire [7:0] pfa_d;
  wire [3:0] pfb_d;
  genvar     gi;

  assign irq_pending_o  = req_any;
  assign prescale_cfg_o = pre_q;
  assign port_dir_o     = dir_q;

  // one cell per flag bit; a hardware set beats a software clear in the same cycle
  // the reserved bit of the first register has no event behind it
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_flag_a
      assign pfa_d[gi] = (wr_pfa ? dat_i[gi] : pfa_q[gi]) | evt_a[gi];
    end
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_flag_b
      assign pfb_d[gi] = (wr_pfb ? dat_i[gi] : pfb_q[gi]) | periph_evt_b_i[gi];
    end
  endgenerate

  // external pins pass two flops first; the old copies feed edge detection
  always @(posedge clk_i)
  begin
    master_clear_pin_s_q   <= {master_clear_pin_s_q[0], master_clear_pin_i};
    edge_s_q   <= {edge_s_q[0], edge_irq_pin_i};
    chg_s_q    <= {chg_s_q[0], port_change_i};
    master_clear_pin_old_q <= master_clear_pin_s_q[1];
    edge_old_q <= edge_s_q[1];
    chg_old_q  <= chg_s_q[1];
  end

  // an interrupt wake is one event per sleep, or the pc would creep every cycle
  always @(posedge clk_i)
  begin
    if (rst_i | any_reset | ~sleeping_i)
    begin
      woke_q <= 1'b0;
    end
    else if (irq_wake)
    begin
      woke_q <= 1'b1;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= 8'h00;
      pfa_q  <= 8'h00;
      pfb_q  <= 4'h0;
      pma_q  <= 8'h00;
      pmb_q  <= 4'h0;
      wdx_q  <= 1'b1;
      pdn_q  <= 1'b1;
      por_q  <= 1'b0;
      bor_q  <= 1'b1;
      pre_q  <= `RCIV_ONES;
      dir_q  <= `RCIV_ONES;
      ack_o  <= 1'b0;
      dat_o  <= 32'h0000_0000;
      pc_load_o    <= 1'b0;
      pc_value_o   <= {PC_W{1'b0}};
      stack_push_o <= 1'b0;
      stack_data_o <= {PC_W{1'b0}};
      wake_o <= 1'b0;
      pend_q <= 1'b0;
      lat_q  <= 2'h0;
    end
    else
    begin
      ack_o        <= bus_req;
      pc_load_o    <= 1'b0;
      stack_push_o <= 1'b0;
      wake_o       <= 1'b0;
      if (bus_req & ~we_i)
      begin
        case (adr_i)
          `RCIV_OFF_IRQ_CTRL: dat_o <= {24'h0, ctrl_q};
          `RCIV_OFF_PFLAG_A:  dat_o <= {24'h0, pfa_q};
          `RCIV_OFF_PFLAG_B:  dat_o <= {28'h0, pfb_q};
          `RCIV_OFF_PMASK_A:  dat_o <= {24'h0, pma_q};
          `RCIV_OFF_PMASK_B:  dat_o <= {28'h0, pmb_q};
          `RCIV_OFF_CAUSE:    dat_o <= {24'h0, cause};
          `RCIV_OFF_PRESCALE: dat_o <= {24'h0, pre_q};
          `RCIV_OFF_DIR:      dat_o <= {24'h0, dir_q};
          `RCIV_OFF_PC:       dat_o <= {{(32-PC_W){1'b0}}, pc_i};
          default:            dat_o <= 32'h0000_0000;
        endcase
      end
      // software writes land first so hardware sets below win over a clear
      if (wr)
      begin
        case (adr_i)
          `RCIV_OFF_IRQ_CTRL: ctrl_q <= dat_i[7:0];
          `RCIV_OFF_PFLAG_A:  pfa_q  <= dat_i[7:0];
          `RCIV_OFF_PFLAG_B:  pfb_q  <= dat_i[3:0];
          `RCIV_OFF_PMASK_A:  pma_q  <= dat_i[7:0];
          `RCIV_OFF_PMASK_B:  pmb_q  <= dat_i[3:0];
          `RCIV_OFF_CAUSE:
          begin
            if (dat_i[`RCIV_BIT_POR]) por_q <= 1'b1;
            if (dat_i[`RCIV_BIT_BOR]) bor_q <= 1'b1;
          end
          `RCIV_OFF_PRESCALE: pre_q  <= dat_i[7:0];
          `RCIV_OFF_DIR:      dir_q  <= dat_i[7:0];
          default:            ;
        endcase
      end
      // events set flags whatever the masks or enables say
      if (edge_evt) ctrl_q[`RCIV_BIT_EDGE_FLAG] <= 1'b1;
      if (chg_evt) ctrl_q[`RCIV_BIT_CHG_FLAG] <= 1'b1;
      if (timer_zero_ovf_i) ctrl_q[`RCIV_BIT_TMR_FLAG] <= 1'b1;
      pfa_q <= pfa_d;
      pfb_q <= pfb_d;
      if (return_from_irq_op_i) ctrl_q[`RCIV_BIT_GIE] <= 1'b1;
      // external pin events see sync delay plus two ticks, giving 3 or 4 cycles
      if (take & ~pend_q)
      begin
        pend_q <= 1'b1;
        lat_q  <= 2'h0;
      end
      // latency counts instruction ticks only, never instruction length
      if (pend_q & instr_tick_i)
      begin
        lat_q <= lat_q + 2'h1;
      end
      if (pend_q & instr_tick_i & (lat_q == `RCIV_IRQ_TICKS - 2'h1))
      begin
        pend_q       <= 1'b0;
        ctrl_q[`RCIV_BIT_GIE] <= 1'b0;
        stack_push_o <= 1'b1;
        stack_data_o <= ret_pc;
        pc_load_o    <= 1'b1;
        pc_value_o   <= `RCIV_IRQ_VEC;
      end
      // sleep wake by interrupt, flag stays set to name the cause
      if (irq_wake)
      begin
        wdx_q  <= 1'b1;
        pdn_q  <= 1'b0;
        wake_o <= 1'b1;
        if (~ctrl_q[`RCIV_BIT_GIE])
        begin
          pc_load_o  <= 1'b1;
          pc_value_o <= ret_pc;
        end
      end
      if (watchdog_evt_i & sleeping_i & ~por_evt_i & ~bor_evt_i & ~master_clear_pin_evt)
      begin
        wdx_q      <= 1'b0;
        pdn_q      <= 1'b0;
        wake_o     <= 1'b1;
        pc_load_o  <= 1'b1;
        pc_value_o <= ret_pc;
      end
      // resets, highest cause first
      if (any_reset)
      begin
        ctrl_q       <= 8'h00;
        pfa_q        <= 8'h00;
        pfb_q        <= 4'h0;
        pma_q        <= 8'h00;
        pmb_q        <= 4'h0;
        pend_q       <= 1'b0;
        stack_push_o <= 1'b0;
        pre_q        <= `RCIV_ONES;
        dir_q        <= `RCIV_ONES;
        pc_load_o    <= 1'b1;
        pc_value_o   <= `RCIV_RESET_VEC;
        if (por_evt_i)
        begin
          wdx_q <= 1'b1;
          pdn_q <= 1'b1;
          por_q <= 1'b0;
        end
        else if (bor_evt_i)
        begin
          bor_q <= 1'b0;
          wdx_q <= 1'b1;
          pdn_q <= 1'b1;
        end
        else if (master_clear_pin_evt & sleeping_i)
        begin
          wdx_q <= 1'b1;
          pdn_q <= 1'b0;
        end
        else if (watchdog_evt_i & ~master_clear_pin_evt)
        begin
          wdx_q <= 1'b0;
          pdn_q <= 1'b1;
        end
      end
    end
  end

endmodule // rciv_unit

// ---- test/rciv_checker.sv ----
// Purpose: port assertions for rciv_unit
// Assumes: pc_i held steady by the core model around a push
// Notes:   bound from the bench top file
`timescale 1ns/10ps
module rciv_checker #(
  parameter PC_W = 13
) (
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            cyc_i,
  input wire logic            stb_i,
  input wire logic            ack_o,
  input wire logic            por_evt_i,
  input wire logic            bor_evt_i,
  input wire logic            watchdog_evt_i,
  input wire logic            sleeping_i,
  input wire logic            pc_load_o,
  input wire logic            stack_push_o,
  input wire logic            wake_o,
  input wire logic [PC_W-1:0] pc_i,
  input wire logic [PC_W-1:0] pc_value_o,
  input wire logic [PC_W-1:0] stack_data_o,
  input wire logic [7:0]      prescale_cfg_o,
  input wire logic [7:0]      port_dir_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  chk_por_pc: assert property (por_evt_i |=> pc_load_o && pc_value_o == 0)
    else $error("power-on pc");
  chk_bor_pc: assert property (bor_evt_i |=> pc_load_o && pc_value_o == 0)
    else $error("brown-out pc");
  chk_reset_ones: assert property (por_evt_i || bor_evt_i |=>
    prescale_cfg_o == 8'hFF && port_dir_o == 8'hFF) else $error("reset ones");
  chk_wdt_awake: assert property (watchdog_evt_i && !sleeping_i |=>
    pc_load_o && pc_value_o == 0) else $error("watchdog reset pc");
  chk_wdt_wake: assert property (watchdog_evt_i && sleeping_i && !por_evt_i && !bor_evt_i
    |=> wake_o && pc_load_o && pc_value_o == $past(pc_i) + 1)
    else $error("watchdog wake pc");
  chk_irq_vec: assert property (stack_push_o |-> pc_load_o && pc_value_o == 13'h0004)
    else $error("vector");
  chk_irq_ret: assert property (stack_push_o |-> stack_data_o == pc_i + 1)
    else $error("return address");
  cover property (stack_push_o);
  cover property (wake_o);
  cover property (bor_evt_i);
endmodule // rciv_checker

// ---- test/rciv_core_model.sv ----
// Purpose: core sequencer and stack stand-in
// Assumes: pc only moves when the unit loads it
// Notes:   a frozen pc keeps every pc+1 expectation exact
`timescale 1ns/10ps
module rciv_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        pc_load_i,
  input  wire logic        push_i,
  input  wire logic [12:0] pc_value_i,
  input  wire logic [12:0] push_data_i,
  output logic             tick_o,
  output logic [12:0]      pc_o,
  output logic [12:0]      top_o,
  output integer           pushes_o
);
  always @(posedge clk_i)
  begin
    tick_o <= ~tick_o & ~rst_i;
    if (rst_i)
    begin
      pc_o <= 13'h0123;
      pushes_o <= 0;
    end
    else
    begin
      if (pc_load_i) pc_o <= pc_value_i;
      if (push_i) top_o <= push_data_i;
      if (push_i) pushes_o <= pushes_o + 1;
    end
  end
endmodule // rciv_core_model

// ---- test/rciv_unit_tb_top.sv ----
// Purpose: self-checking bench for rciv_unit
// Assumes: core model never advances pc by itself
// Notes:   events come from one vector so one task pulses any of them
`timescale 1ns/10ps
module rciv_unit_tb_top;
  logic        clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, sleeping_i = 0;
  logic        master_clear_pin_i = 0, edge_irq_pin_i = 0, port_change_i = 0;
  logic        instr_tick_i, ack_o, pc_load_o, stack_push_o, wake_o, irq_pending_o;
  logic [5:0]  adr_i = '0, ev = '0;
  logic [3:0]  sel_i = 4'h1, periph_evt_b_i = '0;
  logic [7:0]  prescale_cfg_o, port_dir_o;
  logic [12:0] pc_i, pc_value_o, stack_data_o, top, e;
  logic [31:0] dat_i = '0, dat_o, q;
  integer      failures = 0, cmp_count = 0, pushes, k;
  wire         por_evt_i = ev[0], bor_evt_i = ev[1], watchdog_evt_i = ev[2];
  wire         return_from_irq_op_i = ev[3], timer_zero_ovf_i = ev[4];
  wire [6:0]   periph_evt_a_i = {6'h00, ev[5]};
  rciv_unit uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .por_evt_i(por_evt_i), .bor_evt_i(bor_evt_i), .master_clear_pin_i(master_clear_pin_i),
    .watchdog_evt_i(watchdog_evt_i), .sleeping_i(sleeping_i), .instr_tick_i(instr_tick_i),
    .pc_i(pc_i), .return_from_irq_op_i(return_from_irq_op_i),
    .edge_irq_pin_i(edge_irq_pin_i), .port_change_i(port_change_i),
    .timer_zero_ovf_i(timer_zero_ovf_i), .periph_evt_a_i(periph_evt_a_i),
    .periph_evt_b_i(periph_evt_b_i), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
    .stack_push_o(stack_push_o), .stack_data_o(stack_data_o), .wake_o(wake_o),
    .irq_pending_o(irq_pending_o), .prescale_cfg_o(prescale_cfg_o),
    .port_dir_o(port_dir_o));
  rciv_core_model core (.clk_i(clk_i), .rst_i(rst_i), .pc_load_i(pc_load_o),
    .push_i(stack_push_o), .pc_value_i(pc_value_o), .push_data_i(stack_data_o),
    .tick_o(instr_tick_i), .pc_o(pc_i), .top_o(top), .pushes_o(pushes));
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // request held until ack is sampled high, then one idle cycle
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    integer n;
  begin
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'h1 && n < 50);
    q = dat_o;
    if (n >= 50) failures++;
    {cyc_i, stb_i} <= 2'h0;
    @(posedge clk_i);
  end
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] x);
  begin
    wb(1'h0, a, '0);
    chk(q, x);
  end
  endtask
  task automatic pulse(input logic [5:0] m);
  begin
    ev <= m;
    @(posedge clk_i);
    ev <= '0;
    repeat (4) @(posedge clk_i);
  end
  endtask
  // pin passes a two-flop synchroniser, so hold it well past that
  task automatic master_clear_pin;
  begin
    master_clear_pin_i <= 1'h1;
    repeat (6) @(posedge clk_i);
    master_clear_pin_i <= 1'h0;
    repeat (6) @(posedge clk_i);
  end
  endtask
  task automatic t_cause;
  begin
    rd(6'h14, 32'h19);
    rd(6'h00, 32'h00);
    chk(prescale_cfg_o & port_dir_o, 32'hFF);
    rd(6'h24, 32'h00);
    wb(1'h1, 6'h18, 32'h00);
    wb(1'h1, 6'h14, 32'h03);
    rd(6'h14, 32'h1B);
    pulse(6'h02);
    rd(6'h14, 32'h1A);
    chk({prescale_cfg_o, pc_i}, 32'h1FE000);
    pulse(6'h04);
    rd(6'h14, 32'h0A);
    master_clear_pin;
    rd(6'h14, 32'h0A);
    sleeping_i <= 1'h1;
    e = pc_i + 13'h1;
    pulse(6'h04);
    rd(6'h14, 32'h02);
    chk(pc_i, e);
    master_clear_pin;
    rd(6'h14, 32'h12);
    pulse(6'h04);
    wb(1'h1, 6'h00, 32'h20);
    e = pc_i + 13'h1;
    pulse(6'h10);
    rd(6'h14, 32'h12);
    chk(pc_i, e);
    rd(6'h00, 32'h24);
    sleeping_i <= 1'h0;
    pulse(6'h01);
    wb(1'h0, 6'h14, '0);
    chk(q & 32'h1A, 32'h18);
    rd(6'h00, 32'h00);
  end
  endtask
  task automatic t_irq;
  begin
    k = pushes;
    pulse(6'h10);
    rd(6'h00, 32'h04);
    chk(pushes, k);
    wb(1'h1, 6'h00, 32'h00);
    wb(1'h1, 6'h0C, 32'h01);
    wb(1'h1, 6'h00, 32'hC0);
    e = pc_i + 13'h1;
    pulse(6'h20);
    for (int n = 0; n < 20 && pushes == k; n++) @(posedge clk_i);
    chk({pc_i, top}, {13'h0004, e});
    rd(6'h00, 32'h40);
    chk(irq_pending_o, 1'h1);
    wb(1'h1, 6'h04, 32'h00);
    chk(irq_pending_o, 1'h0);
    pulse(6'h08);
    rd(6'h00, 32'hC0);
    chk(pushes, k + 1);
    wb(1'h1, 6'h00, 32'h90);
    k = 0;
    edge_irq_pin_i <= 1'h1;
    for (int n = 0; n < 40 && stack_push_o !== 1'h1; n++)
    begin
      @(posedge clk_i);
      if (instr_tick_i === 1'h1) k++;
    end
    chk(k == 3 || k == 4, 1'h1);
    edge_irq_pin_i <= 1'h0;
    port_change_i <= 1'h1;
    periph_evt_b_i <= 4'h8;
    @(posedge clk_i);
    periph_evt_b_i <= 4'h0;
    repeat (6) @(posedge clk_i);
    rd(6'h00, 32'h13);
    rd(6'h08, 32'h08);
  end
  endtask
  task automatic stop_test;
  begin
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_cause;
    t_irq;
    stop_test;
  end
  // whole run is well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_i);
    failures++;
    stop_test;
  end
endmodule // rciv_unit_tb_top
bind rciv_unit rciv_checker #(.PC_W(PC_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .por_evt_i(por_evt_i), .bor_evt_i(bor_evt_i),
  .watchdog_evt_i(watchdog_evt_i), .sleeping_i(sleeping_i), .pc_load_o(pc_load_o),
  .stack_push_o(stack_push_o), .wake_o(wake_o), .pc_i(pc_i), .pc_value_o(pc_value_o),
  .stack_data_o(stack_data_o), .prescale_cfg_o(prescale_cfg_o), .port_dir_o(port_dir_o));
